// ===== logic/serial_port_pkg.sv
// Shared constants, types and frame decode for the serial port block
package serial_port_pkg;
  localparam int BIT_W = 13;
  localparam logic [7:0] IDX_CTRL = 8'h98;
  localparam logic [7:0] IDX_DATA = 8'h99;
  localparam logic [7:0] IDX_POWER = 8'h9a;
  localparam logic [7:0] IDX_BAUD = 8'h9b;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h9c;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h9d;
  localparam int CTRL_MODE_LOW = 7;
  localparam int CTRL_MODE_HIGH = 6;
  localparam int CTRL_MULTIPROC = 5;
  localparam int CTRL_RX_EN = 4;
  localparam int CTRL_TX_NINTH = 3;
  localparam int CTRL_RX_NINTH = 2;
  localparam int CTRL_TX_DONE = 1;
  localparam int CTRL_RX_DONE = 0;
  localparam int POWER_DOUBLE = 7;
  localparam int POWER_FE_SELECT = 6;
  localparam int IRQ_W = 3;
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  localparam int IRQ_FE = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] POWER_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam logic [BIT_W-1:0] DIV_SYNC_SLOW = 13'h00c;
  localparam logic [BIT_W-1:0] DIV_SYNC_FAST = 13'h004;
  localparam logic [BIT_W-1:0] DIV_FIXED_SLOW = 13'h040;
  localparam logic [BIT_W-1:0] DIV_FIXED_FAST = 13'h020;
  localparam logic [BIT_W-1:0] BIT_ONE = 13'h001;
  localparam logic [3:0] FRAME_SYNC = 4'h8;
  localparam logic [3:0] FRAME_10 = 4'ha;
  localparam logic [3:0] FRAME_11 = 4'hb;
  typedef enum logic [1:0] {
    MODE_SYNC8 = 2'h0,
    MODE_ASYNC10 = 2'h1,
    MODE_ASYNC11_FIXED = 2'h2,
    MODE_ASYNC11_VAR = 2'h3
  } serial_mode_type;
  typedef enum logic [1:0] {
    LINK_IDLE = 2'h0,
    LINK_START = 2'h1,
    LINK_SHIFT = 2'h3
  } link_state_type;
  function automatic logic [3:0] frame_bits(input serial_mode_type m);
    if (m == MODE_SYNC8)
      frame_bits = FRAME_SYNC;
    else if (m == MODE_ASYNC10)
      frame_bits = FRAME_10;
    else
      frame_bits = FRAME_11;
  endfunction
endpackage

// ===== logic/serial_ctrl_if.sv
// Control and data path between the register side and the two shifters
`timescale 1ns/10ps
`default_nettype none
interface serial_ctrl_if;
  import serial_port_pkg::*;
  serial_mode_type mode;
  logic [BIT_W-1:0] bit_cycles;
  logic tx_start;
  logic [7:0] tx_data;
  logic tx_ninth;
  logic tx_busy;
  logic tx_done;
  logic tx_line;
  logic tx_sync_clk;
  logic tx_sync_drive;
  logic rx_enable;
  logic rx_sync_go;
  logic rx_line;
  logic rx_busy;
  logic rx_done;
  logic [7:0] rx_data;
  logic rx_ninth;
  logic rx_stop_ok;
  logic rx_sync_clk;
  modport ctrl (output mode, bit_cycles, tx_start, tx_data, tx_ninth, rx_enable,
    rx_sync_go, rx_line, input tx_busy, tx_done, tx_line, tx_sync_clk,
    tx_sync_drive, rx_busy, rx_done, rx_data, rx_ninth, rx_stop_ok, rx_sync_clk);
  modport tx (input mode, bit_cycles, tx_start, tx_data, tx_ninth,
    output tx_busy, tx_done, tx_line, tx_sync_clk, tx_sync_drive);
  modport rx (input mode, bit_cycles, rx_enable, rx_sync_go, rx_line,
    output rx_busy, rx_done, rx_data, rx_ninth, rx_stop_ok, rx_sync_clk);
endinterface
`default_nettype wire

// ===== logic/serial_shift_out.sv
// Transmit shifter: start, data, ninth and stop bits, or the sync shift
`timescale 1ns/10ps
`default_nettype none
module serial_shift_out
  import serial_port_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  serial_ctrl_if.tx link
);
  link_state_type state;
  logic [BIT_W-1:0] cnt;
  logic [3:0] idx;
  logic [10:0] shreg;
  wire sync_mode = link.mode == MODE_SYNC8;
  wire [3:0] last_idx = frame_bits(link.mode) - 4'h1;
  wire last_cnt = cnt == link.bit_cycles - BIT_ONE;
  wire past_half = cnt >= (link.bit_cycles >> 1);
  wire [10:0] load = sync_mode ? {3'h7, link.tx_data} :
    (link.mode == MODE_ASYNC10) ? {2'h3, link.tx_data, 1'h0} :
    {1'h1, link.tx_ninth, link.tx_data, 1'h0}; // [R7]
  assign link.tx_busy = state != LINK_IDLE;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state <= LINK_IDLE;
      cnt <= '0;
      idx <= 4'h0;
      shreg <= 11'h7ff;
      link.tx_line <= 1'h1;
      link.tx_sync_clk <= 1'h1;
      link.tx_sync_drive <= 1'h0;
      link.tx_done <= 1'h0;
    end
    else
    begin
      link.tx_done <= 1'h0;
      link.tx_sync_clk <= !(state == LINK_SHIFT && sync_mode && !past_half);
      link.tx_sync_drive <= state == LINK_SHIFT && sync_mode;
      if (state == LINK_IDLE)
      begin
        link.tx_line <= 1'h1;
        if (link.tx_start) // [R16]
        begin
          shreg <= load;
          idx <= 4'h0;
          cnt <= '0;
          state <= LINK_SHIFT;
        end
      end
      else
      begin
        cnt <= last_cnt ? '0 : cnt + BIT_ONE;
        if (cnt == '0)
        begin
          link.tx_line <= shreg[0];
          // Flag rises as the stop bit starts
          if (!sync_mode && idx == last_idx)
            link.tx_done <= 1'h1; // [R10]
        end
        if (last_cnt)
        begin
          shreg <= {1'h1, shreg[10:1]};
          idx <= idx + 4'h1;
          if (idx == last_idx)
          begin
            state <= LINK_IDLE;
            if (sync_mode)
              link.tx_done <= 1'h1; // [R10]
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== logic/serial_shift_in.sv
// Receive shifter: start check, mid-bit sampling, sync clocked capture
`timescale 1ns/10ps
`default_nettype none
module serial_shift_in
  import serial_port_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  serial_ctrl_if.rx link
);
  link_state_type state;
  logic [BIT_W-1:0] cnt;
  logic [3:0] idx;
  logic [9:0] shreg;
  logic prev_line;
  wire sync_mode = link.mode == MODE_SYNC8;
  wire [3:0] last_idx = sync_mode ? FRAME_SYNC - 4'h1 : frame_bits(link.mode) - 4'h2;
  wire last_cnt = cnt == link.bit_cycles - BIT_ONE;
  wire half_cnt = cnt == (link.bit_cycles >> 1);
  wire past_half = cnt >= (link.bit_cycles >> 1);
  wire [9:0] next_shreg = {link.rx_line, shreg[9:1]};
  assign link.rx_busy = state != LINK_IDLE;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state <= LINK_IDLE;
      cnt <= '0;
      idx <= 4'h0;
      shreg <= 10'h000;
      prev_line <= 1'h1;
      link.rx_done <= 1'h0;
      link.rx_data <= 8'h00;
      link.rx_ninth <= 1'h0;
      link.rx_stop_ok <= 1'h0;
      link.rx_sync_clk <= 1'h1;
    end
    else
    begin
      prev_line <= link.rx_line;
      link.rx_done <= 1'h0;
      link.rx_sync_clk <= !(state == LINK_SHIFT && sync_mode && !past_half);
      cnt <= (state == LINK_IDLE || last_cnt) ? '0 : cnt + BIT_ONE;
      if (!link.rx_enable)
        state <= LINK_IDLE; // [R6]
      else if (state == LINK_IDLE)
      begin
        idx <= 4'h0;
        if (sync_mode ? link.rx_sync_go : (prev_line && !link.rx_line))
          state <= sync_mode ? LINK_SHIFT : LINK_START;
      end
      else if (state == LINK_START)
      begin
        // A glitch shorter than half a bit is not a start bit
        if (half_cnt)
        begin
          cnt <= '0;
          state <= link.rx_line ? LINK_IDLE : LINK_SHIFT;
        end
      end
      else if (last_cnt)
      begin
        shreg <= next_shreg;
        idx <= idx + 4'h1;
        if (idx == last_idx)
        begin
          state <= LINK_IDLE;
          link.rx_done <= 1'h1; // [R12]
          link.rx_stop_ok <= sync_mode || next_shreg[9];
          if (sync_mode)
            link.rx_data <= next_shreg[9:2];
          else if (link.mode == MODE_ASYNC10)
            link.rx_data <= next_shreg[8:1];
          else
            link.rx_data <= next_shreg[7:0];
          link.rx_ninth <= (link.mode == MODE_ASYNC10) ? next_shreg[9] : next_shreg[8];
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== logic/serial_port_control.sv
// Serial port top: Avalon-MM register file, flags, interrupt and pins
// How it works
// R1 - Control bit 7 is the low mode bit or the framing error flag, as the power register picks.
// R2 - A bad stop bit sets the framing error flag and only a software write clears it.
// R3 - In modes 2 and 3 with multiprocessor mode on, a frame whose ninth bit is 0 sets no receive flag.
// R4 - In mode 1 with multiprocessor mode on, a frame without a valid stop bit sets no receive flag.
// R5 - In mode 0 the shift clock is the clock over 12, or over 4 when multiprocessor bit is set.
// R6 - Reception runs only while the receive enable bit 4 is one.
// R7 - In modes 2 and 3 control bit 3 goes out as the ninth data bit; only software changes it.
// R8 - In modes 2 and 3 the ninth received bit lands in control bit 2; mode 0 leaves it alone.
// R9 - In mode 1 with multiprocessor mode off, the received stop bit lands in control bit 2.
// R10 - The transmit flag rises after the 8th bit in mode 0, else as the stop bit begins.
// R11 - Software clears the transmit flag; hardware only ever sets it.
// R12 - The receive flag rises after the 8th bit in mode 0, else in mid stop bit, if accepted.
// R13 - The receive flag stays set until a software write clears it.
// R14 - The mode bits pick sync 8-bit, async 10-bit variable, 11-bit fixed or 11-bit variable.
// R15 - The data address reads the receive buffer and writes the separate transmit buffer.
// R16 - A write to the transmit buffer starts a new frame in the selected mode; here a write while a frame is still shifting starts none.
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module serial_port_control
  import serial_port_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  output logic txd,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_drive_n
);
  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic mode_sel_low;
  logic mode_sel_high;
  logic multiproc_enable;
  logic rx_enable;
  logic tx_ninth_bit;
  logic rx_ninth_bit;
  logic tx_complete_flag;
  logic rx_complete_flag;
  logic frame_error_flag;
  logic double_rate;
  logic frame_err_select;
  logic [7:0] baud_div;
  logic [7:0] rx_buffer;
  logic [7:0] tx_buffer;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic tx_start;
  logic rxd_meta;
  logic rxd_sync2;
  logic rxd_sync3;
  logic rxd_level;
  logic [31:0] next_readdata;

  serial_ctrl_if link ();

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  // Offsets are register indices; the byte address is four times the index
  wire [7:0] index = address[9:2];
  wire hit_ctrl = index == IDX_CTRL;
  wire hit_data = index == IDX_DATA;
  wire hit_power = index == IDX_POWER;
  wire hit_baud = index == IDX_BAUD;
  wire hit_status = index == IDX_IRQ_STATUS;
  wire hit_mask = index == IDX_IRQ_MASK;
  wire take = (read || write) && !waitrequest;
  wire wr_lane = take && write && byteenable[0];
  wire wr_ctrl = wr_lane && hit_ctrl;
  wire wr_data = wr_lane && hit_data;
  wire wr_power = wr_lane && hit_power;
  wire wr_baud = wr_lane && hit_baud;
  wire wr_status = wr_lane && hit_status;
  wire wr_mask = wr_lane && hit_mask;
  wire [7:0] wd = writedata[7:0];

  ////////////////////////////////////////////////////////////////////////
  // Mode and rate
  wire serial_mode_type mode = serial_mode_type'({mode_sel_low, mode_sel_high}); // [R14]
  wire sync_mode = mode == MODE_SYNC8;
  wire ninth_mode = mode == MODE_ASYNC11_FIXED || mode == MODE_ASYNC11_VAR;
  wire [8:0] baud_steps = {1'h0, baud_div} + 9'h001;
  wire [BIT_W-1:0] var_cycles = {baud_steps, 4'h0};
  wire [BIT_W-1:0] sync_cycles = multiproc_enable ? DIV_SYNC_FAST : DIV_SYNC_SLOW; // [R5]
  wire [BIT_W-1:0] fixed_cycles = double_rate ? DIV_FIXED_FAST : DIV_FIXED_SLOW;
  assign link.mode = mode;
  assign link.bit_cycles = sync_mode ? sync_cycles :
    (mode == MODE_ASYNC11_FIXED) ? fixed_cycles : var_cycles; // [R14]

  ////////////////////////////////////////////////////////////////////////
  // Receive acceptance
  // Multiprocessor filter: address frames carry a one in the ninth bit
  wire mp_reject_ninth = ninth_mode && multiproc_enable && !link.rx_ninth; // [R3]
  wire mp_reject_stop = mode == MODE_ASYNC10 && multiproc_enable && !link.rx_stop_ok; // [R4]
  wire rx_accept = link.rx_done && !mp_reject_ninth && !mp_reject_stop; // [R12]
  wire fe_set = link.rx_done && !sync_mode && !link.rx_stop_ok; // [R2]
  wire ninth_load = rx_accept && !sync_mode; // [R8] [R9]
  wire [IRQ_W-1:0] events = {fe_set, rx_accept, link.tx_done};

  ////////////////////////////////////////////////////////////////////////
  // Shifter hookup
  assign link.tx_start = tx_start;
  assign link.tx_data = tx_buffer;
  assign link.tx_ninth = tx_ninth_bit; // [R7]
  assign link.rx_enable = rx_enable; // [R6]
  // Sync receive waits for the old byte to be taken and the line to be free
  assign link.rx_sync_go = sync_mode && !rx_complete_flag && !link.tx_busy;
  assign link.rx_line = rxd_level;

  serial_shift_out tx_unit (
    .clk(clk),
    .sys_rst(sys_rst),
    .link(link.tx)
  );

  serial_shift_in rx_unit (
    .clk(clk),
    .sys_rst(sys_rst),
    .link(link.rx)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read mux
  wire [7:0] ctrl_view = {frame_err_select ? frame_error_flag : mode_sel_low, // [R1]
    mode_sel_high, multiproc_enable, rx_enable, tx_ninth_bit, rx_ninth_bit,
    tx_complete_flag, rx_complete_flag};

  always_comb
  begin
    next_readdata = 32'h0000_0000;
    if (hit_ctrl)
      next_readdata[7:0] = ctrl_view;
    else if (hit_data)
      next_readdata[7:0] = rx_buffer; // [R15]
    else if (hit_power)
      next_readdata[POWER_DOUBLE] = double_rate;
    else if (hit_baud)
      next_readdata[7:0] = baud_div;
    else if (hit_status)
      next_readdata[IRQ_W-1:0] = irq_status;
    else if (hit_mask)
      next_readdata[IRQ_W-1:0] = irq_mask;
    if (hit_power)
      next_readdata[POWER_FE_SELECT] = frame_err_select;
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake: every access is answered one cycle after it is seen
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      waitrequest <= 1'h1;
      readdata <= 32'h0000_0000;
    end
    else if (take)
      waitrequest <= 1'h1;
    else if (read || write)
    begin
      waitrequest <= 1'h0;
      readdata <= read ? next_readdata : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register bits
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mode_sel_low <= CTRL_RESET[CTRL_MODE_LOW];
      mode_sel_high <= CTRL_RESET[CTRL_MODE_HIGH];
      multiproc_enable <= CTRL_RESET[CTRL_MULTIPROC];
      rx_enable <= CTRL_RESET[CTRL_RX_EN];
      tx_ninth_bit <= CTRL_RESET[CTRL_TX_NINTH];
    end
    else if (wr_ctrl)
    begin
      if (!frame_err_select)
        mode_sel_low <= wd[CTRL_MODE_LOW]; // [R1]
      mode_sel_high <= wd[CTRL_MODE_HIGH];
      multiproc_enable <= wd[CTRL_MULTIPROC];
      rx_enable <= wd[CTRL_RX_EN]; // [R6]
      tx_ninth_bit <= wd[CTRL_TX_NINTH]; // [R7]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Hardware set flags: a set in the same cycle as a write wins
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tx_complete_flag <= CTRL_RESET[CTRL_TX_DONE];
      rx_complete_flag <= CTRL_RESET[CTRL_RX_DONE];
      rx_ninth_bit <= CTRL_RESET[CTRL_RX_NINTH];
      frame_error_flag <= 1'h0;
    end
    else
    begin
      if (link.tx_done)
        tx_complete_flag <= 1'h1; // [R10]
      else if (wr_ctrl)
        tx_complete_flag <= wd[CTRL_TX_DONE]; // [R11]
      if (rx_accept)
        rx_complete_flag <= 1'h1; // [R12]
      else if (wr_ctrl)
        rx_complete_flag <= wd[CTRL_RX_DONE]; // [R13]
      if (ninth_load)
        rx_ninth_bit <= link.rx_ninth; // [R8] [R9]
      else if (wr_ctrl)
        rx_ninth_bit <= wd[CTRL_RX_NINTH];
      if (fe_set)
        frame_error_flag <= 1'h1; // [R2]
      else if (wr_ctrl && frame_err_select)
        frame_error_flag <= wd[CTRL_MODE_LOW]; // [R2]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Buffers and rate registers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rx_buffer <= 8'h00;
      tx_buffer <= 8'h00;
      tx_start <= 1'h0;
      double_rate <= POWER_RESET[POWER_DOUBLE];
      frame_err_select <= POWER_RESET[POWER_FE_SELECT];
      baud_div <= BAUD_RESET;
    end
    else
    begin
      // A write while a frame is still shifting starts no frame
      tx_start <= wr_data && !link.tx_busy && !tx_start; // [R16]
      if (wr_data)
        tx_buffer <= wd; // [R15]
      if (rx_accept)
        rx_buffer <= link.rx_data; // [R15]
      if (wr_power)
      begin
        double_rate <= wd[POWER_DOUBLE];
        frame_err_select <= wd[POWER_FE_SELECT]; // [R1]
      end
      if (wr_baud)
        baud_div <= wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt: sticky status, write one to clear, set wins
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      irq_status <= '0;
      irq_mask <= '0;
      irq <= 1'h0;
    end
    else
    begin
      irq_status <= (irq_status & ~(wr_status ? wd[IRQ_W-1:0] : '0)) | events;
      if (wr_mask)
        irq_mask <= wd[IRQ_W-1:0];
      irq <= |(irq_status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pins
  // Three stages; the level moves only once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rxd_meta <= 1'h1;
      rxd_sync2 <= 1'h1;
      rxd_sync3 <= 1'h1;
      rxd_level <= 1'h1;
    end
    else
    begin
      rxd_meta <= rxd_in;
      rxd_sync2 <= rxd_meta;
      rxd_sync3 <= rxd_sync2;
      if (rxd_sync2 == rxd_sync3)
        rxd_level <= rxd_sync3;
    end
  end

  // In mode 0 the transmit pin carries the shift clock, data rides on rxd
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      txd <= 1'h1;
      rxd_out <= 1'h1;
      rxd_drive_n <= 1'h1;
    end
    else
    begin
      txd <= sync_mode ? (link.tx_sync_clk & link.rx_sync_clk) : link.tx_line; // [R5]
      rxd_out <= link.tx_line;
      rxd_drive_n <= !link.tx_sync_drive;
    end
  end
endmodule
`default_nettype wire

// ===== bench/serial_port_props.sv
// Port-level checker for the serial port register bus and pins
`timescale 1ns/10ps
`default_nettype none
module serial_port_props
  import serial_port_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic irq,
  input wire logic txd,
  input wire logic rxd_drive_n
);
  wire [7:0] idx = address[9:2];
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  a_wait_release: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_rest: assert property (!read && !write |=> waitrequest)
    else $error("waitrequest low with no request");
  // Reset is synchronous, so its effect is seen one edge later
  a_rst_idle: assert property (disable iff (1'b0) sys_rst |=>
    waitrequest && !irq && txd && rxd_drive_n && readdata == 32'h0)
    else $error("outputs not idle after reset");
  a_high_zero: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  a_unmapped_zero: assert property (read && !waitrequest &&
    (idx < IDX_CTRL || idx > IDX_IRQ_MASK) |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_mask_off: assert property (write && !waitrequest && byteenable[0] &&
    idx == IDX_IRQ_MASK && writedata[2:0] == 3'h0 |=> ##1 !irq)
    else $error("irq stays high with mask cleared");
  a_read_hold: assert property (waitrequest ##1 waitrequest |-> $stable(readdata))
    else $error("read data changed without an access");
endmodule
bind serial_port_control serial_port_props chk_i (.clk, .sys_rst, .address, .read,
  .write, .byteenable, .writedata, .readdata, .waitrequest, .irq, .txd, .rxd_drive_n);
`default_nettype wire

// ===== bench/serial_peer.sv
// Remote asynchronous serial device: sends frames and captures frames
`timescale 1ns/10ps
`default_nettype none
module serial_peer (
  input wire logic clk,
  input wire logic txd,
  output logic line
);
  initial line = 1'b1;
  // LSB first after the start bit; the line rests high as a pulled-up wire
  task automatic send(input logic [10:0] f, input int n, input int per);
    for (int i = 0; i < n; i++)
    begin
      line <= f[i];
      repeat (per) @(posedge clk);
    end
    line <= 1'b1;
  endtask
  // Samples mid-bit; the wait for a start bit gives up after 5000 cycles
  task automatic grab(input int n, input int per, output logic [10:0] f);
    int k;
    k = 0;
    f = 11'h000;
    while (txd !== 1'b0 && k < 5000)
    begin
      @(posedge clk);
      k++;
    end
    repeat (per / 2) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      f[i] = txd;
      repeat (per) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the serial port control block
`timescale 1ns/10ps
`default_nettype none
module tb
  import serial_port_pkg::*;
;
  logic clk, sys_rst, read, write, irq, txd, rxd_in, rxd_out, rxd_drive_n, waitrequest;
  logic [9:0] address;
  logic [31:0] writedata, readdata;
  logic [7:0] q;
  logic [10:0] f;
  int n_errors, n_tests, p;
  serial_port_control uut (.clk(clk), .sys_rst(sys_rst), .address(address),
    .read(read), .write(write), .byteenable(4'hf), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .txd(txd),
    .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_drive_n(rxd_drive_n));
  serial_peer peer (.clk(clk), .txd(txd), .line(rxd_in));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e)
    begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] i, input logic [7:0] d,
    output logic [7:0] r);
    int k;
    k = 0;
    @(posedge clk);
    address <= {i, 2'b00};
    writedata <= {24'h000000, d};
    write <= w;
    read <= !w;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (waitrequest !== 1'b0 && k < 100);
    // A bus that never answers counts against the run
    if (k >= 100)
      n_errors++;
    r = readdata[7:0];
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] r;
    acc(1'b1, i, d, r);
  endtask
  task automatic cb(input int b, input logic e);
    logic [7:0] r;
    acc(1'b0, IDX_CTRL, 8'h00, r);
    chk("ctrl_bit", {7'h00, r[b]}, {7'h00, e});
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    n_errors++;
    stop_test;
  end
  initial
  begin
    sys_rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 10'h000;
    writedata = 32'h0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    acc(1'b0, IDX_CTRL, 8'h00, q);
    chk("ctrl_reset", q, CTRL_RESET);
    acc(1'b0, 8'h10, 8'h00, q);
    chk("unmapped", q, 8'h00);
    // Transmit in mode 1 raises the done flag and the irq
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_CTRL, 8'h40);
    fork
      peer.grab(10, 16, f);
      wr(IDX_DATA, 8'ha5);
    join
    chk("tx_frame", f[9:2], {1'b1, 7'h52});
    chk("tx_low", {6'h00, f[1:0]}, 8'h02);
    cb(CTRL_TX_DONE, 1'b1);
    cb(CTRL_TX_DONE, 1'b1);
    chk("irq_tx", {7'h00, irq}, 8'h01);
    wr(IDX_IRQ_STATUS, 8'h01);
    repeat (3) @(posedge clk);
    chk("irq_clr", {7'h00, irq}, 8'h00);
    // Reception disabled, then enabled
    wr(IDX_CTRL, 8'h40);
    peer.send({1'b1, 8'h3c, 1'b0}, 10, 16);
    cb(CTRL_RX_DONE, 1'b0);
    wr(IDX_CTRL, 8'h50);
    wr(IDX_IRQ_MASK, 8'h02);
    peer.send({1'b1, 8'h3c, 1'b0}, 10, 16);
    cb(CTRL_RX_DONE, 1'b1);
    cb(CTRL_RX_NINTH, 1'b1);
    acc(1'b0, IDX_DATA, 8'h00, q);
    chk("rx_data", q, 8'h3c);
    chk("irq_rx", {7'h00, irq}, 8'h01);
    wr(IDX_IRQ_MASK, 8'h00);
    repeat (3) @(posedge clk);
    chk("irq_mask", {7'h00, irq}, 8'h00);
    cb(CTRL_RX_DONE, 1'b1);
    // Bad stop bit with the error role selected and the filter on
    wr(IDX_POWER, 8'h40);
    wr(IDX_CTRL, 8'h70);
    peer.send({1'b0, 8'h55, 1'b0}, 10, 16);
    cb(CTRL_MODE_LOW, 1'b1);
    cb(CTRL_RX_DONE, 1'b0);
    wr(IDX_CTRL, 8'h70);
    cb(CTRL_MODE_LOW, 1'b0);
    wr(IDX_POWER, 8'h00);
    // Mode 3 address filter on the ninth bit
    wr(IDX_CTRL, 8'hf0);
    peer.send({2'b10, 8'h66, 1'b0}, 11, 16);
    cb(CTRL_RX_DONE, 1'b0);
    peer.send({2'b11, 8'h99, 1'b0}, 11, 16);
    cb(CTRL_RX_DONE, 1'b1);
    cb(CTRL_RX_NINTH, 1'b1);
    // Ninth bit out in mode 3 and in mode 2 at the fixed rate
    for (int i = 0; i < 2; i++)
    begin
      wr(IDX_CTRL, i == 0 ? 8'hc8 : 8'h80);
      fork
        peer.grab(11, i == 0 ? 16 : 64, f);
        wr(IDX_DATA, 8'h5a);
      join
      chk("ninth", {7'h00, f[9]}, i == 0 ? 8'h01 : 8'h00);
      chk("data", f[8:1], 8'h5a);
    end
    // Mode 0 shift clock period for both settings
    for (int i = 0; i < 2; i++)
    begin
      wr(IDX_CTRL, i == 0 ? 8'h00 : 8'h20);
      wr(IDX_DATA, 8'hc1);
      p = 0;
      while (txd !== 1'b0 && p < 5000)
      begin
        @(posedge clk);
        p++;
      end
      p = 0;
      while (txd === 1'b0)
      begin
        @(posedge clk);
        p++;
      end
      while (txd === 1'b1)
      begin
        @(posedge clk);
        p++;
      end
      chk("sync_period", p[7:0], i == 0 ? 8'h0c : 8'h04);
      chk("drive_n", {7'h00, rxd_drive_n}, 8'h00);
      chk("rxd_out", {7'h00, rxd_out}, 8'h00);
      repeat (120) @(posedge clk);
      cb(CTRL_TX_DONE, 1'b1);
    end
    stop_test;
  end
endmodule
`default_nettype wire
